//--- rtl/rstp_device.sv
// Device end: serial slave with register array and seconds carry hold-off
// Behaviour
// R1: Session spans chip-enable high, whole bytes.
// R2: Command byte: address high nibble, format low.
// R3: Clock level at enable rise picks edges.
// R4: Every byte shifted most significant bit first.
// R5: Format 8h writes one byte at pointer.
// R6: After single byte, end or new command.
// R7: Format 0h writes successive bytes at pointer.
// R8: Burst advances pointer, Fh wraps to 0h.
// R9: Burst ends only when chip-enable falls.
// R10: Format Ch reads one byte at pointer.
// R11: Format 4h reads consecutive bytes from pointer.
// R12: Single reads and writes mix freely.
// R13: Hold seconds carry during enable, release on fall.
// R14: Carry held at most one second.
// R15: Host keeps enable high through time access.
// R16: Host keeps enable high under one second.
// R17: Failing host must drop enable.
// R18: Host waits 31 us before time registers.
// R19: Host keeps enable low 62 us between.
// R20: Guards may be skipped when carry-free.
// R21: Indoor trim value 7Fh at 7h.
// R22: Outdoor trim value 7Eh.
// R23: Output undriven unless shifting read data.
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
module rstp_device
  import rstp_pkg::*;
#(
  parameter int HOLD_LIMIT = rstp_pkg::HOLD_CYCLES
) (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Serial link
  rstp_if.dev             link,
  // Timekeeping side
  input  wire logic       sec_tick,
  output logic            sec_carry,
  input  wire logic       usr_wr,
  input  wire logic [3:0] usr_addr,
  input  wire logic [7:0] usr_wdata,
  output logic [7:0]      usr_rdata,
  output logic            wr_strobe,
  output logic [3:0]      wr_addr,
  output logic [7:0]      wr_data,
  output logic [7:0]      rate_trim
);
  import rstp_pkg::*;

  typedef enum logic [2:0] {DS_CMD, DS_WR1, DS_WRB, DS_RD1, DS_RDB} rstp_dev_state_type;

  function automatic logic [3:0] next_addr(input logic [3:0] a);
    next_addr = a + 4'h1; // R8
  endfunction : next_addr

  logic [2:0]         pins_s;
  logic               ce_s;
  logic               sclk_s;
  logic               si_s;
  logic               ce_p_q;
  logic               sclk_p_q;
  logic               pol_q;
  rstp_dev_state_type state_q;
  logic [2:0]         bit_q;
  logic [7:0]         rx_q;
  logic [7:0]         tx_q;
  logic [3:0]         addr_q;
  logic [7:0]         mem_q [16];
  logic               so_q;
  logic               so_oe_q;
  logic               pend_q;
  logic [31:0]        hold_q;
  logic               ce_rise;
  logic               ce_fall;
  logic               sclk_rise;
  logic               sclk_fall;
  logic               in_edge;
  logic               out_edge;
  logic               byte_done;
  logic [7:0]         byte_in;
  logic               reading;
  logic               hold_done;

  rstp_sync #(.W(3)) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       ({link.ce, link.sclk, link.si}),
    .q       (pins_s)
  );

  assign ce_s      = pins_s[2];
  assign sclk_s    = pins_s[1];
  assign si_s      = pins_s[0];
  assign ce_rise   = ce_s & ~ce_p_q;
  assign ce_fall   = ~ce_s & ce_p_q;
  assign sclk_rise = sclk_s & ~sclk_p_q;
  assign sclk_fall = ~sclk_s & sclk_p_q;
  assign in_edge   = ce_s & (pol_q ? sclk_rise : sclk_fall); // R3
  assign out_edge  = ce_s & (pol_q ? sclk_fall : sclk_rise); // R3
  assign byte_in   = {rx_q[6:0], si_s}; // R4
  assign byte_done = in_edge && (bit_q == 3'd7); // R1
  assign reading   = (state_q == DS_RD1) || (state_q == DS_RDB);
  assign hold_done = (hold_q >= 32'(HOLD_LIMIT));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ce_p_q   <= 1'b0;
      sclk_p_q <= 1'b0;
      pol_q    <= 1'b0;
    end else begin
      ce_p_q   <= ce_s;
      sclk_p_q <= sclk_s;
      if (ce_rise) begin
        pol_q <= sclk_s; // R3
      end
    end
  end

  // Command decode and pointer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= DS_CMD;
      bit_q   <= 3'd0;
      rx_q    <= 8'h00;
      addr_q  <= 4'h0;
    end else if (!ce_s) begin
      state_q <= DS_CMD; // R1 R9
      bit_q   <= 3'd0;
    end else if (in_edge) begin
      rx_q  <= byte_in;
      bit_q <= bit_q + 3'd1;
      if (bit_q == 3'd7) begin
        case (state_q)
          DS_CMD: begin
            addr_q <= byte_in[7:4]; // R2
            case (byte_in[3:0])
              FMT_WR1: state_q <= DS_WR1; // R5
              FMT_WRB: state_q <= DS_WRB; // R7
              FMT_RD1: state_q <= DS_RD1; // R10
              FMT_RDB: state_q <= DS_RDB; // R11
              // Unknown formats leave the port waiting for a command
              default: state_q <= DS_CMD;
            endcase
          end
          DS_WR1, DS_RD1: state_q <= DS_CMD; // R6 R12
          DS_WRB, DS_RDB: addr_q <= next_addr(addr_q); // R8 R9
          default: state_q <= DS_CMD;
        endcase
      end
    end
  end

  // Register array; serial write wins over user write to the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 16; i++) begin
        mem_q[i] <= MEM_RESET;
      end
    end else if (byte_done && ((state_q == DS_WR1) || (state_q == DS_WRB))) begin
      mem_q[addr_q] <= byte_in; // R5 R7
    end else if (usr_wr) begin
      mem_q[usr_addr] <= usr_wdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_strobe <= 1'b0;
      wr_addr   <= 4'h0;
      wr_data   <= 8'h00;
      usr_rdata <= 8'h00;
      rate_trim <= MEM_RESET;
    end else begin
      wr_strobe <= byte_done && ((state_q == DS_WR1) || (state_q == DS_WRB));
      if (byte_done) begin
        wr_addr <= addr_q;
        wr_data <= byte_in;
      end
      usr_rdata <= mem_q[usr_addr];
      rate_trim <= mem_q[ADDR_TRIM]; // R21 R22
    end
  end

  // Read shifter: loaded as the command or previous byte completes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_q    <= 8'h00;
      so_q    <= 1'b0;
      so_oe_q <= 1'b0;
    end else begin
      so_oe_q <= ce_s && reading; // R23
      if (byte_done && (state_q == DS_CMD)) begin
        tx_q <= mem_q[byte_in[7:4]]; // R10 R11
      end else if (byte_done && (state_q == DS_RDB)) begin
        tx_q <= mem_q[next_addr(addr_q)]; // R8 R11
      end else if (out_edge && reading) begin
        so_q <= tx_q[7]; // R4
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end

  assign link.so    = so_q;
  assign link.so_oe = so_oe_q;

  // Seconds carry hold-off; a carry older than the limit escapes anyway
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_q    <= 1'b0;
      hold_q    <= 32'd0;
      sec_carry <= 1'b0;
    end else begin
      sec_carry <= 1'b0;
      if (pend_q && (!ce_s || hold_done)) begin
        sec_carry <= 1'b1; // R13 R14
        pend_q    <= 1'b0;
        hold_q    <= 32'd0;
      end else if (pend_q) begin
        hold_q <= hold_q + 32'd1;
      end
      if (sec_tick) begin
        if (ce_s && !ce_fall) begin
          pend_q <= 1'b1; // R13
          if (!pend_q || hold_done) begin
            hold_q <= 32'd0;
          end
        end else begin
          sec_carry <= 1'b1;
          // A held carry released in this cycle stays pending one more
          if (pend_q) begin
            pend_q <= 1'b1; // R13
          end
        end
      end
    end
  end
endmodule : rstp_device

//--- rtl/rstp_host.sv
// Host end: AHB-Lite command registers driving the serial link
`timescale 1ns/1ps
module rstp_host
  import rstp_pkg::*;
#(
  parameter int CE_MAX = rstp_pkg::CE_MAX_CYCLES,
  parameter int HALF   = rstp_pkg::HALF_CYCLES
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Serial link
  rstp_if.host             link
);
  import rstp_pkg::*;

  logic [2:0]  ctrl_q;
  logic        dp_we_q;
  logic [7:0]  dp_addr_q;
  logic [7:0]  txd_q;
  logic [7:0]  rxd_q;
  logic [7:0]  sh_q;
  logic        pend_q;
  logic        busy_q;
  logic [4:0]  hcnt_q;
  logic [15:0] div_q;
  logic        tick;
  logic        ce_q;
  logic        sclk_q;
  logic        si_q;
  logic        tmo_q;
  logic [15:0] gap_q;
  logic [15:0] grd_q;
  logic [31:0] hi_q;
  logic        so_s;
  logic        take;
  logic        wr_ctrl;
  logic        wr_tx;
  logic        gap_ok;
  logic        grd_ok;
  logic        idle_lvl;

  rstp_sync #(.W(1)) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       (link.so_line),
    .q       (so_s)
  );

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign take      = hsel && hready && htrans[1];
  assign wr_ctrl   = dp_we_q && (dp_addr_q == OFF_CTRL);
  assign wr_tx     = dp_we_q && (dp_addr_q == OFF_TX);
  assign idle_lvl  = ctrl_q[CTRL_IDLE_BIT];
  // R20
  assign gap_ok    = ctrl_q[CTRL_NOGRD_BIT] || (gap_q >= 16'(GAP_CYCLES));
  assign grd_ok    = ctrl_q[CTRL_NOGRD_BIT] || (grd_q >= 16'(GUARD_CYCLES));
  assign tick      = (div_q == 16'(HALF - 1));

  // Bus slave: zero wait states, read data captured in the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_we_q   <= 1'b0;
      dp_addr_q <= 8'h00;
      hrdata    <= 32'h0000_0000;
      ctrl_q    <= CTRL_RESET;
      txd_q     <= 8'h00;
    end else begin
      dp_we_q   <= take && hwrite;
      dp_addr_q <= haddr[7:0];
      if (take && !hwrite) begin
        case (haddr[7:0])
          OFF_CTRL: hrdata <= {29'h0, ctrl_q};
          OFF_TX:   hrdata <= {24'h0, txd_q};
          OFF_RX:   hrdata <= {24'h0, rxd_q};
          OFF_STAT: hrdata <= {28'h0, pend_q, tmo_q, ce_q, busy_q};
          default:  hrdata <= 32'h0000_0000;
        endcase
      end
      if (wr_ctrl) begin
        ctrl_q <= hwdata[2:0];
      end
      if (wr_tx) begin
        txd_q <= hwdata[7:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q <= 16'd0;
    end else if (!busy_q || tick) begin
      div_q <= 16'd0;
    end else begin
      div_q <= div_q + 16'd1;
    end
  end

  // Chip-enable with its guard times and one-second ceiling
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ce_q  <= 1'b0;
      tmo_q <= 1'b0;
      gap_q <= 16'd0;
      grd_q <= 16'd0;
      hi_q  <= 32'd0;
    end else begin
      if (wr_ctrl && !hwdata[CTRL_CE_BIT]) begin
        tmo_q <= 1'b0;
      end
      if (ce_q) begin
        gap_q <= 16'd0;
        hi_q  <= hi_q + 32'd1;
        if (!grd_ok) begin
          grd_q <= grd_q + 16'd1; // R18
        end
        if (!ctrl_q[CTRL_CE_BIT]) begin
          ce_q <= 1'b0;
        end else if (hi_q >= 32'(CE_MAX)) begin
          ce_q  <= 1'b0; // R16 R17
          tmo_q <= 1'b1;
        end
      end else begin
        grd_q <= 16'd0;
        hi_q  <= 32'd0;
        if (!gap_ok) begin
          gap_q <= gap_q + 16'd1; // R19
        end
        if (ctrl_q[CTRL_CE_BIT] && gap_ok && !tmo_q) begin
          ce_q <= 1'b1; // R1 R15
        end
      end
    end
  end

  // Byte shifter: even halves lead and present data, odd halves trail
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_q <= 1'b0;
      busy_q <= 1'b0;
      hcnt_q <= 5'd0;
      sh_q   <= 8'h00;
      rxd_q  <= 8'h00;
      sclk_q <= 1'b0;
      si_q   <= 1'b0;
    end else if (!ce_q) begin
      busy_q <= 1'b0;
      pend_q <= pend_q || wr_tx;
      sclk_q <= idle_lvl; // R3
    end else if (!busy_q) begin
      sclk_q <= idle_lvl;
      if (wr_tx) begin
        pend_q <= 1'b1;
      end else if (pend_q && grd_ok) begin
        pend_q <= 1'b0;
        busy_q <= 1'b1;
        hcnt_q <= 5'd0;
        sh_q   <= txd_q;
      end
    end else begin
      // A byte queued mid-shift goes out after this one
      if (wr_tx) begin
        pend_q <= 1'b1;
      end
      if (tick) begin
        hcnt_q <= hcnt_q + 5'd1;
        if (!hcnt_q[0]) begin
          if (hcnt_q != 5'd0) begin
            rxd_q <= {rxd_q[6:0], so_s}; // R4
          end
          if (hcnt_q == 5'(BYTE_HALVES)) begin
            busy_q <= 1'b0; // R1
          end else begin
            sclk_q <= ~idle_lvl;
            si_q   <= sh_q[7]; // R4
            sh_q   <= {sh_q[6:0], 1'b0};
          end
        end else begin
          sclk_q <= idle_lvl;
        end
      end
    end
  end

  assign link.ce   = ce_q;
  assign link.sclk = sclk_q;
  assign link.si   = si_q;
endmodule : rstp_host

//--- rtl/rstp_if.sv
// Four-wire serial link between host and device
`timescale 1ns/1ps
interface rstp_if;
  logic ce;
  logic sclk;
  logic si;
  logic so;
  logic so_oe;
  logic so_line;
  // Undriven serial output reads high through a pull-up
  assign so_line = so_oe ? so : 1'b1;
  modport dev  (input ce, input sclk, input si, output so, output so_oe);
  modport host (output ce, output sclk, output si, input so_line);
endinterface : rstp_if

//--- rtl/rstp_pkg.sv
// Shared constants of the RTC serial transfer port
package rstp_pkg;
  // Transfer format codes, low nibble of the command byte
  localparam logic [3:0] FMT_WR1 = 4'h8;
  localparam logic [3:0] FMT_WRB = 4'h0;
  localparam logic [3:0] FMT_RD1 = 4'hC;
  localparam logic [3:0] FMT_RDB = 4'h4;
  // Device register map
  localparam logic [3:0] ADDR_TRIM    = 4'h7;
  localparam logic [7:0] TRIM_INDOOR  = 8'h7F;
  localparam logic [7:0] TRIM_OUTDOOR = 8'h7E;
  localparam logic [7:0] MEM_RESET    = 8'h00;
  // Host command registers, byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_TX   = 8'h04;
  localparam logic [7:0] OFF_RX   = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0C;
  localparam int CTRL_CE_BIT    = 0;
  localparam int CTRL_IDLE_BIT  = 1;
  localparam int CTRL_NOGRD_BIT = 2;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_CE_BIT    = 1;
  localparam int STAT_TMO_BIT   = 2;
  localparam int STAT_PEND_BIT  = 3;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  // Timing
  localparam int CLK_PERIOD_NS  = 50;
  localparam int HOLD_TIME_NS   = 1000000000;
  localparam int HOLD_CYCLES    = HOLD_TIME_NS / CLK_PERIOD_NS;
  localparam int CE_MAX_CYCLES  = HOLD_CYCLES - 1;
  localparam int GUARD_TIME_NS  = 31000;
  localparam int GUARD_CYCLES   = (GUARD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_TIME_NS    = 62000;
  localparam int GAP_CYCLES     = (GAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HALF_TIME_NS   = 200;
  localparam int HALF_CYCLES    = HALF_TIME_NS / CLK_PERIOD_NS;
  localparam int BYTE_HALVES    = 16;
endpackage : rstp_pkg

//--- rtl/rstp_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module rstp_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // Asynchronous in, synchronous out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : rstp_sync

//--- sim/rstp_properties.sv
// Assertions on the serial link between host and device
`timescale 1ns/1ps
module rstp_properties #(
  parameter int CE_MAX = 1999
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Link wires
  input wire logic ce,
  input wire logic sclk,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe,
  input wire logic so_line
);
  logic [3:0]  edge_q;
  logic [31:0] high_q;
  logic        sclk_q;
  logic        mode_q;
  logic        first_q;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Idle level is the one held while enable is low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sclk_q <= 1'b0;
      mode_q <= 1'b0;
    end else begin
      sclk_q <= sclk;
      mode_q <= ce ? mode_q : sclk;
    end
  end
  // Sixteen clock changes per byte, so the count wraps on byte ends
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      edge_q  <= 4'h0;
      first_q <= 1'b1;
    end else if (!ce) begin
      edge_q  <= 4'h0;
      first_q <= 1'b1;
    end else if (sclk != sclk_q) begin
      edge_q  <= edge_q + 4'h1;
      first_q <= first_q && (edge_q != 4'hF);
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      high_q <= 32'h0;
    end else begin
      high_q <= ce ? high_q + 32'h1 : 32'h0;
    end
  end
  ce_mode_a: assert property ($rose(ce) |-> $stable(sclk))
    else $error("serial clock moved as enable rose");
  half_period_a: assert property (ce && $changed(sclk) |=> $stable(sclk) [*3])
    else $error("serial clock half period too short");
  si_launch_a: assert property (ce && $changed(si) |-> $changed(sclk) && sclk != mode_q)
    else $error("serial input changed off the leading edge");
  si_hold_a: assert property (ce && sclk != mode_q && $stable(sclk) |-> $stable(si))
    else $error("serial input moved while clock away from idle");
  whole_byte_a: assert property ($fell(ce) |-> edge_q == 4'h0 && sclk == mode_q)
    else $error("session ended inside a byte");
  oe_start_a: assert property ($rose(so_oe) |-> ce && !first_q)
    else $error("output driven outside read data");
  oe_stop_a: assert property (!ce [*6] |-> !so_oe && so_line)
    else $error("output still driven with enable low");
  ce_limit_a: assert property (high_q <= CE_MAX + 2)
    else $error("enable held high too long");
  so_shift_a: assert property (so_oe && $changed(so) |-> edge_q[0])
    else $error("serial output changed off the output edge");
endmodule : rstp_properties

//--- sim/rtc_serial_transfer_port_tb_top.sv
// Self-checking bench: host and device joined over the serial link
`timescale 1ns/1ps
module rtc_serial_transfer_port_tb_top;
  import rstp_pkg::*;
  localparam int HOLD = 1000;
  localparam int CEMX = 1999;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        hready, hresp, sec_carry, wr_strobe;
  logic [31:0] hrdata, rd;
  logic        sec_tick = 1'b0, usr_wr = 1'b0, idle = 1'b0, skip = 1'b1, sclk_p = 1'b0;
  logic [3:0]  usr_addr = 4'h0, a, wa;
  logic [7:0]  usr_wdata = 8'h0, usr_rdata, rate_trim, r, tv, wdv;
  logic [7:0]  exp_mem [16];
  int          err_total = 0, total_checks = 0, seed = 65, carries = 0, strobes = 0;
  int          edges = 0, lo_n = 0, hi_n = 0, gap_n = 0, lead_n = -1, c0;
  rstp_if rstp_if_i ();
  rstp_device #(.HOLD_LIMIT(HOLD)) rstp_device_i (
    .hclk(hclk), .hresetn(hresetn), .link(rstp_if_i), .sec_tick(sec_tick),
    .sec_carry(sec_carry), .usr_wr(usr_wr), .usr_addr(usr_addr), .usr_wdata(usr_wdata),
    .usr_rdata(usr_rdata), .wr_strobe(wr_strobe), .wr_addr(wa), .wr_data(wdv),
    .rate_trim(rate_trim));
  rstp_host #(.CE_MAX(CEMX), .HALF(HALF_CYCLES)) rstp_host_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .link(rstp_if_i));
  rstp_properties #(.CE_MAX(CEMX)) rstp_properties_i (
    .hclk(hclk), .hresetn(hresetn), .ce(rstp_if_i.ce), .sclk(rstp_if_i.sclk),
    .si(rstp_if_i.si), .so(rstp_if_i.so), .so_oe(rstp_if_i.so_oe),
    .so_line(rstp_if_i.so_line));
  always #25 hclk = ~hclk;
  // Link activity counters, sampled once a cycle
  always @(posedge hclk) begin
    sclk_p <= rstp_if_i.sclk;
    if (rstp_if_i.sclk !== sclk_p) edges <= edges + 1;
    if (sec_carry === 1'b1) carries <= carries + 1;
    if (wr_strobe === 1'b1) strobes <= strobes + 1;
    lo_n <= rstp_if_i.ce ? 0 : lo_n + 1;
    hi_n <= rstp_if_i.ce ? hi_n + 1 : 0;
    if (rstp_if_i.ce === 1'b1 && lo_n != 0) gap_n <= lo_n;
    if (rstp_if_i.ce !== 1'b1) lead_n <= -1;
    else if (lead_n < 0 && rstp_if_i.sclk !== idle) lead_n <= hi_n;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      err_total++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : chk
  // Burst pointer after n bytes, wrapping from Fh to 0h
  function automatic logic [3:0] burst_addr(input logic [3:0] base, input int n);
    burst_addr = 4'(base + n);
  endfunction : burst_addr
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict
  // Single bus transfer; hangs are left to the watchdog
  task automatic ahb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, ad};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic ce_set(input logic on);
    ahb(1'b1, OFF_CTRL, {29'h0, skip, idle, on});
    repeat (8) @(posedge hclk);
  endtask : ce_set
  // Completion by counting clock changes, since busy may lag the write
  task automatic xfer(input logic [7:0] b, output logic [7:0] q);
    int e0;
    e0 = edges;
    ahb(1'b1, OFF_TX, {24'h0, b});
    while (edges < e0 + 16) @(posedge hclk);
    do ahb(1'b0, OFF_STAT, 32'h0); while (rd[STAT_BUSY_BIT] !== 1'b0 || rd[STAT_PEND_BIT] !== 1'b0);
    ahb(1'b0, OFF_RX, 32'h0);
    q = rd[7:0];
  endtask : xfer
  task automatic pulse;
    sec_tick <= 1'b1;
    @(posedge hclk);
    sec_tick <= 1'b0;
  endtask : pulse
  initial begin
    #2000000;
    err_total++;
    $display("unexpected at %0t: watchdog expired", $time);
    give_verdict();
  end
  initial begin
    foreach (exp_mem[i]) exp_mem[i] = MEM_RESET;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, OFF_CTRL, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b0, OFF_STAT, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b1, 8'h10, 32'hFFFF_FFFF);
    ahb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    chk(32'(rate_trim), 32'(MEM_RESET));
    chk(32'({hready, hresp}), 32'h2);
    $display("test reset done");
    for (int m = 0; m < 2; m++) begin
      idle = m[0];
      c0 = strobes;
      ce_set(1'b0);
      ce_set(1'b1);
      tv = m[0] ? TRIM_OUTDOOR : TRIM_INDOOR;
      xfer({ADDR_TRIM, FMT_WR1}, r);
      xfer(tv, r);
      exp_mem[ADDR_TRIM] = tv;
      chk(32'(wa), 32'(ADDR_TRIM));
      chk(32'(wdv), 32'(tv));
      a = 4'($random(seed));
      xfer({a, FMT_RD1}, r);
      xfer(8'($random(seed)), r);
      chk(32'(r), 32'(exp_mem[a]));
      tv = ~exp_mem[a];
      xfer({a, FMT_WR1}, r);
      xfer(tv, r);
      exp_mem[a] = tv;
      xfer({4'hE, FMT_WRB}, r);
      for (int i = 0; i < 3; i++) begin
        tv = 8'($random(seed));
        xfer(tv, r);
        exp_mem[burst_addr(4'hE, i)] = tv;
      end
      ce_set(1'b0);
      chk(32'(strobes - c0), 32'd5);
      ce_set(1'b1);
      xfer({4'hF, FMT_RDB}, r);
      for (int i = 0; i < 3; i++) begin
        xfer(8'($random(seed)), r);
        chk(32'(r), 32'(exp_mem[burst_addr(4'hF, i)]));
      end
      ce_set(1'b0);
      chk(32'(rate_trim), 32'(exp_mem[ADDR_TRIM]));
      for (int i = 0; i < 16; i++) begin
        usr_addr <= 4'(i);
        repeat (2) @(posedge hclk);
        chk(32'(usr_rdata), 32'(exp_mem[i]));
      end
      $display("test mode %0d done", m);
    end
    idle = 1'b0;
    usr_addr <= 4'h5;
    usr_wdata <= 8'($random(seed));
    usr_wr <= 1'b1;
    @(posedge hclk);
    usr_wr <= 1'b0;
    exp_mem[5] = usr_wdata;
    skip = 1'b0;
    ce_set(1'b0);
    ce_set(1'b1);
    c0 = strobes;
    // Unknown format is ignored and the next byte is a command again
    xfer({4'h3, 4'h1}, r);
    xfer({4'h5, FMT_RD1}, r);
    xfer(8'h3C, r);
    chk(32'(r), 32'(exp_mem[5]));
    chk(32'(strobes - c0), 32'h0);
    chk(32'(lead_n >= GUARD_CYCLES), 32'h1);
    chk(32'(gap_n >= GAP_CYCLES), 32'h1);
    skip = 1'b1;
    ce_set(1'b0);
    $display("test guard done");
    c0 = carries;
    pulse();
    repeat (3) @(posedge hclk);
    chk(32'(carries), 32'(c0 + 1));
    ce_set(1'b1);
    pulse();
    repeat (500) @(posedge hclk);
    chk(32'(carries), 32'(c0 + 1));
    ce_set(1'b0);
    chk(32'(carries), 32'(c0 + 2));
    ce_set(1'b1);
    pulse();
    repeat (HOLD - 100) @(posedge hclk);
    chk(32'(carries), 32'(c0 + 2));
    repeat (150) @(posedge hclk);
    chk(32'(carries), 32'(c0 + 3));
    repeat (CEMX - HOLD) @(posedge hclk);
    ahb(1'b0, OFF_STAT, 32'h0);
    chk(32'(rd[STAT_TMO_BIT:STAT_CE_BIT]), 32'h2);
    ce_set(1'b0);
    ahb(1'b0, OFF_STAT, 32'h0);
    chk(32'(rd[STAT_TMO_BIT]), 32'h0);
    $display("test carry done");
    give_verdict();
  end
endmodule : rtc_serial_transfer_port_tb_top
